/* hw/usart_tx_consts.vh */
// Register indices, field positions, reset values and timing figures of the transmitter.
`ifndef USART_TX_CONSTS_VH
`define USART_TX_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_INTERRUPT_CONTROL 10'h00b
`define IDX_PERIPHERAL_IRQ_FLAGS 10'h00c
`define IDX_RECEIVE_STATUS_CONTROL 10'h018
`define IDX_TRANSMIT_BUFFER 10'h019
`define IDX_PERIPHERAL_IRQ_ENABLES 10'h08c
`define IDX_TRANSMIT_STATUS_CONTROL 10'h098
`define IDX_BAUD_DIVISOR 10'h099

// Field positions in interrupt_control.
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_MASTER_ENABLE 6

// Field positions in peripheral_irq_flags and peripheral_irq_enables.
`define BIT_BUFFER_EMPTY 4

// Field positions in receive_status_control.
`define BIT_PORT_ENABLE 7
`define BIT_NINE_BIT_RECEIVE 6
`define BIT_SINGLE_RECEIVE_ENABLE 5
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4

// Field positions in transmit_status_control.
`define BIT_MASTER_CLOCK_SELECT 7
`define BIT_NINTH_BIT_SELECT 6
`define BIT_TRANSMIT_ENABLE 5
`define BIT_CLOCKED_MODE 4
`define BIT_SHIFT_EMPTY_STATUS 1
`define BIT_NINTH_TRANSMIT_BIT 0

// Reset values.
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_RECEIVE_STATUS_CONTROL 8'h00
`define RST_TRANSMIT_BUFFER 8'h00
`define RST_PERIPHERAL_IRQ_ENABLES 8'h00
`define RST_TRANSMIT_STATUS_CONTROL 8'h02
`define RST_BAUD_DIVISOR 8'h00

// Word lengths in shift clocks.
`define BITS_SHORT_WORD 4'h8
`define BITS_LONG_WORD 4'h9

`endif

/* hw/usart_sync_master_tx.v */
// Synchronous master transmit path of the serial port with its APB register file.
`timescale 1ns/100ps
// Behaviour
// - Shift register reloads only after the last bit of the previous word.
// - Buffer to shift register move takes one cycle, then buffer-empty flag sets.
// - Buffer-empty flag ignores its enable, software cannot clear it, buffer write clears.
// - Transmit interrupt request is gated by the buffer-empty interrupt enable.
// - Read-only shift-empty status bit is high while the shift register is empty.
// - Transmit enable permits sending; nothing goes out before a buffer write.
// - Each bit launches on a rising shift clock, stable around the falling edge.
// - Baud generator held in reset while transmit and both receive enables are clear.
// - Writing the buffer before setting transmit enable also starts a transfer.
// - Write to empty shift register passes straight through; words go back to back.
// - Clearing transmit enable aborts, resets transmitter, releases data and clock.
// - A receive enable aborts sending, frees the data line, clock stays if master.
// - Receive abort keeps transmitter state; only transmit enable clear resets it.
// - Single receive enable clears after one word; data drive then resumes.
// - Nine-bit mode selected by status bit 6; ninth bit comes from bit 0.
// - Ninth bit is captured when the word enters the shift register.
// - Clocked mode and port enable turn the pins into clock and data lines.
// - Shift clock is driven on the clock line when master clock is selected.
// - Half duplex: receiving inhibits transmitting; a receive enable still takes effect while sending.
`include "usart_tx_consts.vh"

module usart_sync_master_tx
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq_to_core,
    output reg shift_clock_line_out,
    output reg shift_clock_line_oe,
    output reg serial_data_line_out,
    output reg serial_data_line_oe
);

    // ****************************************************************
    // Register file
    // ****************************************************************

    reg [7:0] interrupt_control;
    reg [7:0] receive_status_control;
    reg [7:0] transmit_buffer;
    reg [7:0] peripheral_irq_enables;
    reg [7:0] transmit_status_control;
    reg [7:0] baud_divisor;
    reg buffer_empty_flag;
    reg buffer_full;

    // Transmitter state.
    reg [8:0] output_shift_register;
    reg shift_full;
    reg [3:0] bit_count;
    reg [3:0] word_bits;
    reg shift_clock;
    reg [7:0] baud_count;
    reg [3:0] receive_count;

    wire [9:0] reg_index;
    wire bus_write;
    wire bus_read;
    wire transmit_enable;
    wire single_rx;
    wire continuous_rx;
    wire receiving;
    wire baud_run;
    wire baud_tick;
    wire tx_running;
    wire clock_running;
    wire last_fall;
    wire load_shift;
    wire buffer_write;
    wire receive_done;
    wire [3:0] receive_bits;
    wire port_on;
    wire next_shift_clock;
    reg [7:0] read_value;
    reg read_hit;

    // Word address from the byte address; the two low bits select nothing.
    assign reg_index = paddr[11:2];

    // A write takes effect at the edge where the slave shows ready; read data is latched one edge earlier.
    assign bus_write = psel & penable & pready & pwrite;
    assign bus_read = psel & penable & ~pready & ~pwrite;
    assign buffer_write = bus_write & (reg_index == `IDX_TRANSMIT_BUFFER);

    // Mode decode of the control bits.
    assign transmit_enable = transmit_status_control[`BIT_TRANSMIT_ENABLE];
    assign single_rx = receive_status_control[`BIT_SINGLE_RECEIVE_ENABLE];
    assign continuous_rx = receive_status_control[`BIT_CONTINUOUS_RECEIVE_ENABLE];
    assign receiving = single_rx | continuous_rx;
    assign port_on = receive_status_control[`BIT_PORT_ENABLE]
        & transmit_status_control[`BIT_CLOCKED_MODE];

    // ****************************************************************
    // Baud generator
    // ****************************************************************

    // The generator sits in reset with all three enables clear, so a slow
    // rate still gives a full first half period once it is released.
    assign baud_run = transmit_enable | receiving;
    assign baud_tick = baud_run & (baud_count == 8'h00);

    // Each tick marks one half period of the shift clock.
    // The count reloads from the divisor, so a tick comes every divisor plus one cycles.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            baud_count <= 8'h00;
        else if (!baud_run)
            baud_count <= baud_divisor;
        else if (baud_count == 8'h00)
            baud_count <= baud_divisor;
        else
            baud_count <= baud_count - 8'h01;
    end

    // ****************************************************************
    // Shift clock and word sequencing
    // ****************************************************************

    // A receive enable freezes the transmitter without clearing it.
    assign tx_running = transmit_enable & shift_full & ~receiving;
    assign clock_running = tx_running | receiving;
    assign last_fall = tx_running & baud_tick & shift_clock & (bit_count == word_bits);

    // Load when the shift register is empty, or straight after the last
    // bit has gone so that words follow with no idle clock between them.
    assign load_shift = transmit_enable & buffer_full
        & (~shift_full | last_fall);

    // Single-word receive length follows the receive nine-bit select.
    assign receive_bits = receive_status_control[`BIT_NINE_BIT_RECEIVE]
        ? `BITS_LONG_WORD : `BITS_SHORT_WORD;

    // The single word is done after its last falling clock edge.
    assign receive_done = single_rx & ~continuous_rx & baud_tick & shift_clock
        & (receive_count == receive_bits - 4'h1);

    // Next value of the internal shift clock. The clock pin register loads it
    // as well, so the pin moves on the same edge as the data pin; a pin that
    // trailed by one cycle would let a fast clock fall while data changes.
    assign next_shift_clock = clock_running & (baud_tick ? ~shift_clock : shift_clock);

    // Shift clock idles low and toggles on each tick while in use.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shift_clock <= 1'b0;
        else if (!clock_running)
            shift_clock <= 1'b0;
        else if (baud_tick)
            shift_clock <= ~shift_clock;
    end

    // Counts received clocks of a single-word receive; continuous has precedence.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            receive_count <= 4'h0;
        else if (!single_rx || continuous_rx || receive_done)
            receive_count <= 4'h0;
        else if (baud_tick && shift_clock)
            receive_count <= receive_count + 4'h1;
    end

    // Shift register: bit launch on rising edges, lsb first.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_shift_register <= 9'h000;
            shift_full <= 1'b0;
            bit_count <= 4'h0;
            word_bits <= `BITS_SHORT_WORD;
            serial_data_line_out <= 1'b0;
        end
        else if (!transmit_enable)
        begin
            // The data pin keeps its last level; it is released anyway, and a
            // change here could meet the final falling clock edge.
            shift_full <= 1'b0;
            bit_count <= 4'h0;
        end
        else if (load_shift)
        begin
            // The ninth bit is taken as it stands now, not as written later.
            output_shift_register <= {transmit_status_control[`BIT_NINTH_TRANSMIT_BIT],
                transmit_buffer};
            word_bits <= transmit_status_control[`BIT_NINTH_BIT_SELECT]
                ? `BITS_LONG_WORD : `BITS_SHORT_WORD;
            shift_full <= 1'b1;
            bit_count <= 4'h0;
        end
        else if (last_fall)
        begin
            shift_full <= 1'b0;
            bit_count <= 4'h0;
        end
        else if (tx_running && baud_tick && !shift_clock)
        begin
            serial_data_line_out <= output_shift_register[0];
            output_shift_register <= {1'b0, output_shift_register[8:1]};
            bit_count <= bit_count + 4'h1;
        end
    end

    // ****************************************************************
    // Transmit buffer and its flag
    // ****************************************************************

    // The buffer holds one word; a write to a full buffer replaces it.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transmit_buffer <= `RST_TRANSMIT_BUFFER;
            buffer_full <= 1'b0;
        end
        else if (buffer_write)
        begin
            transmit_buffer <= pwdata[7:0];
            buffer_full <= 1'b1;
        end
        else if (load_shift)
            buffer_full <= 1'b0;
    end

    // The flag mirrors the buffer except after reset, when it reads clear: a write that meets
    // a load leaves a full buffer, so the write decides. Writes to the flag register never touch it.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            buffer_empty_flag <= 1'b0;
        else if (buffer_write)
            buffer_empty_flag <= 1'b0;
        else if (load_shift)
            buffer_empty_flag <= 1'b1;
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************

    // Software writes; the single receive enable also clears itself.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_control <= `RST_INTERRUPT_CONTROL;
            receive_status_control <= `RST_RECEIVE_STATUS_CONTROL;
            peripheral_irq_enables <= `RST_PERIPHERAL_IRQ_ENABLES;
            transmit_status_control <= `RST_TRANSMIT_STATUS_CONTROL;
            baud_divisor <= `RST_BAUD_DIVISOR;
        end
        else
        begin
            if (bus_write && reg_index == `IDX_INTERRUPT_CONTROL)
                interrupt_control <= pwdata[7:0];
            if (bus_write && reg_index == `IDX_PERIPHERAL_IRQ_ENABLES)
                peripheral_irq_enables <= pwdata[7:0];
            if (bus_write && reg_index == `IDX_BAUD_DIVISOR)
                baud_divisor <= pwdata[7:0];
            // Shift-empty status is read-only; bit 3 is unimplemented.
            if (bus_write && reg_index == `IDX_TRANSMIT_STATUS_CONTROL)
                transmit_status_control <= {pwdata[7:4], 1'b0, pwdata[2], 1'b0,
                    pwdata[0]};
            // A software write in the same cycle as the end of the word wins.
            if (bus_write && reg_index == `IDX_RECEIVE_STATUS_CONTROL)
                receive_status_control <= {pwdata[7:4], 4'h0};
            else if (receive_done)
                receive_status_control[`BIT_SINGLE_RECEIVE_ENABLE] <= 1'b0;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************

    // Read mux; unmapped indices answer zero with an error.
    always @*
    begin
        read_value = 8'h00;
        read_hit = 1'b1;
        case (reg_index)
            `IDX_INTERRUPT_CONTROL:
                read_value = interrupt_control;
            `IDX_PERIPHERAL_IRQ_FLAGS:
                read_value = {3'h0, buffer_empty_flag, 4'h0};
            `IDX_RECEIVE_STATUS_CONTROL:
                read_value = receive_status_control;
            `IDX_TRANSMIT_BUFFER:
                read_value = transmit_buffer;
            `IDX_PERIPHERAL_IRQ_ENABLES:
                read_value = peripheral_irq_enables;
            `IDX_TRANSMIT_STATUS_CONTROL:
                read_value = {transmit_status_control[7:2], ~shift_full,
                    transmit_status_control[0]};
            `IDX_BAUD_DIVISOR:
                read_value = baud_divisor;
            default:
                read_hit = 1'b0;
        endcase
    end

    // One wait state: ready rises in the second access cycle, with data.
    // Read data stands for the one cycle of ready and then returns to zero.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~read_hit;
            if (bus_read)
                prdata <= {24'h000000, read_value};
            else if (pready)
                prdata <= 32'h00000000;
        end
    end

    // ****************************************************************
    // Pins and interrupt request
    // ****************************************************************

    // Registered pin controls. Data is released while any receive enable
    // is set; the clock stays driven as master while the port is in use.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_clock_line_out <= 1'b0;
            shift_clock_line_oe <= 1'b0;
            serial_data_line_oe <= 1'b0;
            irq_to_core <= 1'b0;
        end
        else
        begin
            // The pin only toggles where it is driven, so a released clock line
            // always shows its idle low level.
            shift_clock_line_out <= next_shift_clock
                & port_on & transmit_status_control[`BIT_MASTER_CLOCK_SELECT];
            shift_clock_line_oe <= port_on
                & transmit_status_control[`BIT_MASTER_CLOCK_SELECT]
                & (transmit_enable | receiving);
            serial_data_line_oe <= port_on & transmit_enable & ~receiving;
            irq_to_core <= buffer_empty_flag
                & peripheral_irq_enables[`BIT_BUFFER_EMPTY]
                & interrupt_control[`BIT_GLOBAL_IRQ_ENABLE]
                & interrupt_control[`BIT_PERIPHERAL_IRQ_MASTER_ENABLE];
        end
    end

endmodule

/* verification/usart_tx_properties.sv */
// Concurrent checks on the ports of the synchronous master transmitter.
`timescale 1ns/100ps
module usart_tx_properties
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq_to_core,
    input wire shift_clock_line_out,
    input wire shift_clock_line_oe,
    input wire serial_data_line_out,
    input wire serial_data_line_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Register bus handshake
    // ****************************************
    chk_ready_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not after exactly one wait state");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_read_idle_zero: assert property (!$past(pready) |-> prdata == 32'h0 || pready)
        else $error("read data not cleared after the answer");
    // ****************************************
    // Serial pins
    // ****************************************
    chk_clock_driven: assert property ($rose(shift_clock_line_out) |-> shift_clock_line_oe)
        else $error("shift clock rises while not driven");
    chk_data_at_fall: assert property ($fell(shift_clock_line_out) |-> $stable(serial_data_line_out))
        else $error("data changes at a falling shift clock");
    chk_released_low: assert property (!shift_clock_line_oe |-> !shift_clock_line_out)
        else $error("released shift clock not low");
endmodule

bind usart_sync_master_tx usart_tx_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_to_core(irq_to_core),
    .shift_clock_line_out(shift_clock_line_out), .shift_clock_line_oe(shift_clock_line_oe),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe));

/* verification/sync_slave_model.sv */
// Behavioural serial receiver standing on the far side of the clock and data pins.
`timescale 1ns/100ps
module sync_slave_model
(
    input wire logic ck,
    input wire logic ck_oe,
    input wire logic dt,
    input wire logic dt_oe,
    input wire logic nine,
    input wire logic restart,
    output logic [8:0] word,
    output int words
);
    logic [8:0] sh;
    int n;
    initial
    begin
        word = 9'h000;
        words = 0;
        n = 0;
        sh = 9'h000;
    end
    // Sample where the data is stable; a released data line is ignored, so reception gaps skip.
    always @(negedge ck or posedge restart)
    begin
        if (restart)
            n = 0;
        else if (ck_oe && dt_oe)
        begin
            sh[n] = dt;
            n++;
            if (n == (nine ? 9 : 8))
            begin
                word = nine ? sh : {1'b0, sh[7:0]};
                words++;
                n = 0;
            end
        end
    end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the synchronous master transmitter.
`timescale 1ns/100ps
`include "usart_tx_consts.vh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, nine, restart;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire [31:0] prdata;
    wire pready, pslverr, irq_to_core, ck, ck_oe, dt, dt_oe;
    logic [7:0] r;
    logic e;
    logic [8:0] word;
    int words, miscompares, comparisons;
    time t1;
    usart_sync_master_tx dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_to_core(irq_to_core), .shift_clock_line_out(ck),
        .shift_clock_line_oe(ck_oe), .serial_data_line_out(dt), .serial_data_line_oe(dt_oe));
    sync_slave_model slave_u (.ck(ck), .ck_oe(ck_oe), .dt(dt), .dt_oe(dt_oe), .nine(nine),
        .restart(restart), .word(word), .words(words));
    // A 40 ns clock.
    always #20 pclk = ~pclk;
    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input bit w, input [9:0] idx, input [7:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50)
        begin
            miscompares++;
            print_verdict;
        end
    endtask
    task automatic wait_words(input int n);
        int i;
        for (i = 0; i < 3000 && words < n; i++)
            @(posedge pclk);
        if (words < n)
        begin
            miscompares++;
            print_verdict;
        end
    endtask
    // Write one word and compare what the far side received.
    task automatic xfer(input [7:0] d, input [8:0] exp);
        apb(1, `IDX_TRANSMIT_BUFFER, d);
        wait_words(words + 1);
        check("word", word, exp);
    endtask
    initial
    begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, nine, restart} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
        check("tx ctl reset", r, 9'h002);
        apb(0, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        check("flags reset", r, 9'h000);
        apb(1, 10'h3ff, 8'h55);
        check("unmapped err", e, 1);
        $display("test reset done");
        // Setup order kept by software: divisor 3 gives a 320 ns shift clock.
        apb(1, `IDX_BAUD_DIVISOR, 8'h03);
        apb(1, `IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        apb(1, `IDX_PERIPHERAL_IRQ_ENABLES, 8'h10);
        apb(1, `IDX_INTERRUPT_CONTROL, 8'hc0);
        apb(1, `IDX_TRANSMIT_STATUS_CONTROL, 8'hb0);
        xfer(8'ha5, 9'h0a5);
        apb(1, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        apb(0, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        check("flag set", r, 9'h010);
        check("irq", irq_to_core, 1);
        apb(0, `IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
        check("shift empty", r[1], 1);
        apb(1, `IDX_PERIPHERAL_IRQ_ENABLES, 8'h00);
        repeat (2) @(posedge pclk);
        check("irq masked", irq_to_core, 0);
        $display("test single word done");
        apb(1, `IDX_TRANSMIT_BUFFER, 8'h3c);
        apb(1, `IDX_TRANSMIT_BUFFER, 8'hc3);
        apb(0, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        check("flag clear", r, 9'h000);
        apb(0, `IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
        check("shift busy", r[1], 0);
        wait_words(words + 1);
        check("word 1", word, 9'h03c);
        t1 = $time;
        wait_words(words + 1);
        check("word 2", word, 9'h0c3);
        // Eight bits of two half periods of four cycles each: 64 cycles, no gap.
        check("gap", 9'(($time - t1) / 40), 9'd64);
        $display("test back to back done");
        nine = 1'b1;
        apb(1, `IDX_TRANSMIT_STATUS_CONTROL, 8'hf1);
        xfer(8'h5a, 9'h15a);
        apb(1, `IDX_TRANSMIT_BUFFER, 8'h33);
        apb(1, `IDX_TRANSMIT_STATUS_CONTROL, 8'hf0);
        wait_words(words + 1);
        check("ninth captured", word, 9'h133);
        nine = 1'b0;
        $display("test nine bit done");
        apb(1, `IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
        apb(1, `IDX_TRANSMIT_BUFFER, 8'h81);
        repeat (100) @(posedge pclk);
        check("held", ck_oe, 0);
        apb(1, `IDX_TRANSMIT_STATUS_CONTROL, 8'hb0);
        wait_words(words + 1);
        check("late enable", word, 9'h081);
        $display("test enable late done");
        apb(1, `IDX_TRANSMIT_BUFFER, 8'hff);
        repeat (40) @(posedge pclk);
        apb(1, `IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
        repeat (2) @(posedge pclk);
        check("data released", dt_oe, 0);
        check("clock released", ck_oe, 0);
        restart <= 1'b1;
        apb(0, `IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
        restart <= 1'b0;
        check("reset shift", r[1], 1);
        apb(1, `IDX_TRANSMIT_STATUS_CONTROL, 8'hb0);
        $display("test abort done");
        apb(1, `IDX_TRANSMIT_BUFFER, 8'h0f);
        repeat (40) @(posedge pclk);
        // Start the receive just after a rising clock, so the bit in flight is
        // sampled before the freeze and the word resumes with the next bit.
        for (int i = 0; i < 20 && ck !== 1'b0; i++)
            @(posedge pclk);
        for (int i = 0; i < 20 && ck !== 1'b1; i++)
            @(posedge pclk);
        check("clock phase", ck, 1);
        apb(1, `IDX_RECEIVE_STATUS_CONTROL, 8'ha0);
        repeat (2) @(posedge pclk);
        check("rx data", dt_oe, 0);
        check("rx clock", ck_oe, 1);
        r = 8'h20;
        for (int i = 0; i < 30 && r[5]; i++)
            apb(0, `IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        check("single rx", r[5], 0);
        check("resume", dt_oe, 1);
        wait_words(words + 1);
        check("kept word", word, 9'h00f);
        $display("test receive abort done");
        print_verdict;
    end
endmodule
